/* File: common/mmx_pkg.sv */
// ***************************************************************
// Shared constants for the move, multiply and shift execution unit.
// ***************************************************************
package mmx_pkg;

  // ***************************************************************
  // Register map, byte offsets on the bus.
  // ***************************************************************
  localparam logic [7:0] MMX_OFF_CTRL     = 8'h00;
  localparam logic [7:0] MMX_OFF_INSTR    = 8'h04;
  localparam logic [7:0] MMX_OFF_FLAGS    = 8'h08;
  localparam logic [7:0] MMX_OFF_STATUS   = 8'h0C;
  localparam logic [7:0] MMX_OFF_PSP      = 8'h14;
  localparam logic [7:0] MMX_OFF_PRIMASK  = 8'h18;
  localparam logic [7:0] MMX_OFF_CONTROL  = 8'h1C;
  localparam logic [1:0] MMX_GPR_WIN      = 2'h1;

  // ***************************************************************
  // Control register fields and reset value.
  // ***************************************************************
  localparam int         MMX_CTRL_COND_PASS = 0;
  localparam int         MMX_CTRL_IN_BLOCK  = 1;
  localparam int         MMX_CTRL_PRIV      = 2;
  localparam logic [2:0] MMX_CTRL_RESET     = 3'h5;

  // ***************************************************************
  // Flag positions in the four-bit flag word and in the status word.
  // ***************************************************************
  localparam int         MMX_FLAG_N     = 3;
  localparam int         MMX_FLAG_Z     = 2;
  localparam int         MMX_FLAG_C     = 1;
  localparam int         MMX_FLAG_V     = 0;
  localparam int         MMX_APP_STATUS_FLAGS_LSB   = 28;
  localparam logic [3:0] MMX_FLAGS_RESET = 4'h0;

  // ***************************************************************
  // Outcome word of the last executed instruction.
  // ***************************************************************
  localparam int MMX_ST_EXEC   = 0;
  localparam int MMX_ST_BRANCH = 1;
  localparam int MMX_ST_PRIV   = 2;
  localparam int MMX_ST_UNDEF  = 3;
  localparam int MMX_ST_SKIP   = 4;

  // ***************************************************************
  // Opcode patterns.
  // ***************************************************************
  localparam logic [9:0]  MMX_OPC_LSR_REG = 10'h103;
  localparam logic [9:0]  MMX_OPC_MUL     = 10'h10D;
  localparam logic [9:0]  MMX_OPC_MOVE_FLAG_SETTING_OP_R  = 10'h000;
  localparam logic [4:0]  MMX_OPC_MOV_IMM = 5'h04;
  localparam logic [7:0]  MMX_OPC_MOV_R   = 8'h46;
  localparam logic [15:0] MMX_OPC_MRS_HI  = 16'hF3EF;
  localparam logic [3:0]  MMX_OPC_MRS_LO  = 4'h8;
  localparam logic [11:0] MMX_OPC_MSR_HI  = 12'hF38;
  localparam logic [7:0]  MMX_OPC_MSR_LO  = 8'h88;

  // ***************************************************************
  // Special register selector values and register indices.
  // ***************************************************************
  localparam logic [7:0] MMX_SEL_FLAGS   = 8'h00;
  localparam logic [7:0] MMX_SEL_MSP     = 8'h08;
  localparam logic [7:0] MMX_SEL_PSP     = 8'h09;
  localparam logic [7:0] MMX_SEL_PRIMASK = 8'h10;
  localparam logic [7:0] MMX_SEL_CONTROL = 8'h14;
  localparam logic [3:0] MMX_IDX_SP      = 4'hD;
  localparam logic [3:0] MMX_IDX_PC      = 4'hF;
  localparam logic [31:0] MMX_PC_RESET   = 32'h0000_0000;

endpackage

/* File: hdl/mmx_lsr_shifter.sv */
`timescale 1ns/1ps
// ***************************************************************
// Logical right shift by a byte-wide amount with carry out.
// ***************************************************************
module mmx_lsr_shifter
  import mmx_pkg::*;
(
  input  wire logic [31:0] operand,
  input  wire logic [7:0]  amount,
  input  wire logic        carry_in,
  output logic      [31:0] result,
  output logic             carry_out
);

  // Zero amount keeps carry; amounts past the word width clear everything.
  always_comb begin
    if (amount == 8'h00) begin
      result    = operand;
      carry_out = carry_in;
    end else if (amount < 8'h20) begin
      result    = operand >> amount[4:0];
      carry_out = operand[amount[4:0] - 5'h01];
    end else if (amount == 8'h20) begin
      result    = 32'h0000_0000;
      carry_out = operand[31];
    end else begin
      result    = 32'h0000_0000;
      carry_out = 1'b0;
    end
  end

endmodule

/* File: hdl/mmx_gpr_file.sv */
`timescale 1ns/1ps
// ***************************************************************
// General-purpose register array with three read ports and one write.
// ***************************************************************
module mmx_gpr_file
  import mmx_pkg::*;
#(
  parameter int NREG = 15
)
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  rd_a_idx,
  output logic      [31:0] rd_a_data,
  input  wire logic [3:0]  rd_b_idx,
  output logic      [31:0] rd_b_data,
  input  wire logic [3:0]  rd_c_idx,
  output logic      [31:0] rd_c_data,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_idx,
  input  wire logic [31:0] wr_data
);

  if (NREG < 1 || NREG > 15) begin : g_chk
    $error("mmx_gpr_file: NREG must be 1 to 15");
  end

  logic [31:0] gpr_reg [NREG];

  // One flop word per entry; only the addressed entry takes the write.
  for (genvar i = 0; i < NREG; i++) begin : g_ent
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        gpr_reg[i] <= 32'h0000_0000;
      end else if (wr_en && wr_idx == 4'(i)) begin
        gpr_reg[i] <= wr_data;
      end
    end
  end

  // Indices outside the array read as zero.
  assign rd_a_data = (rd_a_idx < NREG[3:0]) ? gpr_reg[rd_a_idx] : 32'h0000_0000;
  assign rd_b_data = (rd_b_idx < NREG[3:0]) ? gpr_reg[rd_b_idx] : 32'h0000_0000;
  assign rd_c_data = (rd_c_idx < NREG[3:0]) ? gpr_reg[rd_c_idx] : 32'h0000_0000;

endmodule

/* File: hdl/mmx_exec_unit.sv */
`timescale 1ns/1ps
// Functional notes
// - Shift right by register uses the low source byte as amount and fills with zeros.
// - Shift right flags outside a block: N from bit 31, Z on zero, C from the last bit out, V kept.
// - Move immediate zero-extends the byte immediate into the 3-bit destination.
// - Move immediate sets N and Z only outside a conditional block and keeps C and V.
// - The first register move takes a 4-bit destination and never sets flags.
// - The second register move uses 3-bit fields and always sets N and Z.
// - A register move to index 15 writes the program counter as a branch without flags.
// - Flag-setting register move sets N from bit 31 and Z from the value, keeping C and V.
// - Special read copies the selection and is privileged except for flags or control.
// - Special write copies a register to the selection and is privileged except for flags.
// - Multiply writes the low product word, the same for signed and unsigned operands.
// - Multiply reuses the destination as second operand and sets flags outside a block.
// - Flag-setting multiply sets N from product bit 31, Z from the low word, keeps C and V.
module mmx_exec_unit
  import mmx_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr
);

  if (ADDR_W < 8) begin : g_chk
    $error("mmx_exec_unit: ADDR_W must be at least 8");
  end

  // ***************************************************************
  // State.
  // ***************************************************************
  logic [2:0]  ctrl_reg;
  logic [3:0]  flags_reg;
  logic [4:0]  status_reg;
  logic [31:0] pc_reg;
  logic [31:0] psp_reg;
  logic        primask_reg;
  logic [1:0]  control_reg;
  logic [31:0] prdata_reg;

  // ***************************************************************
  // Bus decode.
  // ***************************************************************
  logic [7:0]  off;
  logic        hi_zero;
  logic        is_gpr;
  logic [3:0]  gpr_idx;
  logic        mapped;
  logic        wr_acc;
  logic        exec_fire;

  assign off       = paddr[7:0];
  assign hi_zero   = (paddr >> 8) == '0;
  assign is_gpr    = hi_zero && off[7:6] == MMX_GPR_WIN && off[1:0] == 2'h0;
  assign gpr_idx   = off[5:2];
  assign mapped    = is_gpr || (hi_zero && (off == MMX_OFF_CTRL || off == MMX_OFF_INSTR ||
                     off == MMX_OFF_FLAGS || off == MMX_OFF_STATUS || off == MMX_OFF_PSP ||
                     off == MMX_OFF_PRIMASK || off == MMX_OFF_CONTROL));
  assign wr_acc    = psel && penable && pwrite && mapped;
  assign exec_fire = wr_acc && off == MMX_OFF_INSTR;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !mapped;
  assign prdata    = prdata_reg;

  // ***************************************************************
  // Instruction fields.
  // ***************************************************************
  logic [15:0] hw1;
  logic [15:0] hw2;
  logic        narrow;
  logic        is_lsr;
  logic        is_movi;
  logic        is_movr;
  logic        is_move_flag_setting_op;
  logic        is_mul;
  logic        is_mrs;
  logic        is_msr;
  logic        cond_ok;
  logic        out_blk;
  logic [7:0]  sel;

  assign hw1     = pwdata[31:16];
  assign hw2     = pwdata[15:0];
  assign narrow  = hw1 == 16'h0000;
  assign is_lsr  = narrow && hw2[15:6] == MMX_OPC_LSR_REG;
  assign is_movi = narrow && hw2[15:11] == MMX_OPC_MOV_IMM;
  assign is_movr = narrow && hw2[15:8] == MMX_OPC_MOV_R;
  assign is_move_flag_setting_op = narrow && hw2[15:6] == MMX_OPC_MOVE_FLAG_SETTING_OP_R;
  assign is_mul  = narrow && hw2[15:6] == MMX_OPC_MUL;
  assign is_mrs  = hw1 == MMX_OPC_MRS_HI && hw2[15:12] == MMX_OPC_MRS_LO;
  assign is_msr  = hw1[15:4] == MMX_OPC_MSR_HI && hw2[15:8] == MMX_OPC_MSR_LO;
  assign cond_ok = ctrl_reg[MMX_CTRL_COND_PASS];
  assign out_blk = !ctrl_reg[MMX_CTRL_IN_BLOCK];
  assign sel     = hw2[7:0];

  // ***************************************************************
  // Operand fetch.
  // ***************************************************************
  logic [3:0]  a_idx;
  logic [3:0]  b_idx;
  logic [31:0] rf_a;
  logic [31:0] rf_b;
  logic [31:0] rf_c;
  logic [31:0] src_a;
  logic [31:0] src_b;

  // Picks the source fields per encoding.
  always_comb begin
    a_idx = {1'b0, hw2[5:3]};
    b_idx = {1'b0, hw2[2:0]};
    if (is_lsr) begin
      a_idx = {1'b0, hw2[2:0]};
      b_idx = {1'b0, hw2[5:3]};
    end else if (is_movr) begin
      a_idx = hw2[6:3];
    end else if (is_msr) begin
      a_idx = hw1[3:0];
    end
  end

  assign src_a = (a_idx == MMX_IDX_PC) ? pc_reg : rf_a;
  assign src_b = rf_b;

  // ***************************************************************
  // Datapath.
  // ***************************************************************
  logic [31:0] lsr_res;
  logic        lsr_c;
  logic [63:0] prod;
  logic [31:0] mul_res;

  mmx_lsr_shifter u_shift (
    .operand   (src_a),
    .amount    (src_b[7:0]),
    .carry_in  (flags_reg[MMX_FLAG_C]),
    .result    (lsr_res),
    .carry_out (lsr_c)
  );

  // Low word of an unsigned product equals the signed one.
  assign prod    = src_a * src_b;
  assign mul_res = prod[31:0];

  // ***************************************************************
  // Execute outcome.
  // ***************************************************************
  logic        ex_wr;
  logic [3:0]  ex_idx;
  logic [31:0] ex_data;
  logic [3:0]  ex_flags;
  logic        ex_pc_wr;
  logic [4:0]  ex_status;
  logic        sel_free;
  logic [31:0] spec_rd;

  // Read value of the selected special register.
  always_comb begin
    case (sel)
      MMX_SEL_FLAGS:   spec_rd = {flags_reg, 28'h000_0000};
      MMX_SEL_MSP:     spec_rd = rf_c;
      MMX_SEL_PSP:     spec_rd = psp_reg;
      MMX_SEL_PRIMASK: spec_rd = {31'h0000_0000, primask_reg};
      MMX_SEL_CONTROL: spec_rd = {30'h0000_0000, control_reg};
      default:         spec_rd = 32'h0000_0000;
    endcase
  end

  // Forms register write, flags and outcome for the current word.
  always_comb begin
    ex_wr     = 1'b0;
    ex_idx    = {1'b0, hw2[2:0]};
    ex_data   = 32'h0000_0000;
    ex_flags  = flags_reg;
    ex_pc_wr  = 1'b0;
    ex_status = '0;
    sel_free  = 1'b0;
    if (!cond_ok) begin
      ex_status[MMX_ST_SKIP] = 1'b1;
    end else begin
      ex_status[MMX_ST_EXEC] = 1'b1;
      if (is_lsr) begin
        ex_wr   = 1'b1;
        ex_data = lsr_res;
        if (out_blk) begin
          ex_flags[MMX_FLAG_N] = lsr_res[31];
          ex_flags[MMX_FLAG_Z] = lsr_res == 32'h0000_0000;
          ex_flags[MMX_FLAG_C] = lsr_c;
        end
      end else if (is_movi) begin
        ex_wr   = 1'b1;
        ex_idx  = {1'b0, hw2[10:8]};
        ex_data = {24'h00_0000, hw2[7:0]};
        if (out_blk) begin
          ex_flags[MMX_FLAG_N] = 1'b0;
          ex_flags[MMX_FLAG_Z] = hw2[7:0] == 8'h00;
        end
      end else if (is_movr || is_move_flag_setting_op) begin
        ex_idx  = is_movr ? {hw2[7], hw2[2:0]} : {1'b0, hw2[2:0]};
        ex_data = src_a;
        if (ex_idx == MMX_IDX_PC) begin
          ex_pc_wr                 = 1'b1;
          ex_status[MMX_ST_BRANCH] = 1'b1;
        end else begin
          ex_wr = 1'b1;
        end
        if (is_move_flag_setting_op) begin
          ex_flags[MMX_FLAG_N] = src_a[31];
          ex_flags[MMX_FLAG_Z] = src_a == 32'h0000_0000;
        end
      end else if (is_mul) begin
        ex_wr   = 1'b1;
        ex_data = mul_res;
        if (out_blk) begin
          ex_flags[MMX_FLAG_N] = mul_res[31];
          ex_flags[MMX_FLAG_Z] = mul_res == 32'h0000_0000;
        end
      end else if (is_mrs) begin
        sel_free = sel == MMX_SEL_FLAGS || sel == MMX_SEL_CONTROL;
        if (hw2[11:8] == MMX_IDX_PC) begin
          ex_status[MMX_ST_UNDEF] = 1'b1;
        end else if (sel_free || ctrl_reg[MMX_CTRL_PRIV]) begin
          ex_wr   = 1'b1;
          ex_idx  = hw2[11:8];
          ex_data = spec_rd;
        end else begin
          ex_status[MMX_ST_PRIV] = 1'b1;
        end
      end else if (is_msr) begin
        sel_free = sel == MMX_SEL_FLAGS;
        if (sel_free) begin
          ex_flags = src_a[31:MMX_APP_STATUS_FLAGS_LSB];
        end else if (!ctrl_reg[MMX_CTRL_PRIV]) begin
          ex_status[MMX_ST_PRIV] = 1'b1;
        end else if (sel == MMX_SEL_MSP) begin
          ex_wr   = 1'b1;
          ex_idx  = MMX_IDX_SP;
          ex_data = src_a;
        end
      end else begin
        ex_status[MMX_ST_UNDEF] = 1'b1;
      end
    end
  end

  // ***************************************************************
  // Register array, shared between execution and bus writes.
  // ***************************************************************
  logic        rf_we;
  logic [3:0]  rf_widx;
  logic [31:0] rf_wdata;

  assign rf_we    = (exec_fire && ex_wr) || (wr_acc && is_gpr && gpr_idx != MMX_IDX_PC);
  assign rf_widx  = exec_fire ? ex_idx : gpr_idx;
  assign rf_wdata = exec_fire ? ex_data : pwdata;

  mmx_gpr_file #(
    .NREG (15)
  ) u_gpr (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .rd_a_idx  (a_idx),
    .rd_a_data (rf_a),
    .rd_b_idx  (b_idx),
    .rd_b_data (rf_b),
    .rd_c_idx  (is_gpr ? gpr_idx : MMX_IDX_SP),
    .rd_c_data (rf_c),
    .wr_en     (rf_we),
    .wr_idx    (rf_widx),
    .wr_data   (rf_wdata)
  );

  // ***************************************************************
  // Flags, outcome and program counter.
  // ***************************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags_reg  <= MMX_FLAGS_RESET;
      status_reg <= '0;
    end else if (exec_fire) begin
      flags_reg  <= ex_flags;
      status_reg <= ex_status;
    end else if (wr_acc && off == MMX_OFF_FLAGS) begin
      flags_reg  <= pwdata[31:MMX_APP_STATUS_FLAGS_LSB];
    end
  end

  // A branch clears bit 0 of the target, as an interworking write would.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pc_reg <= MMX_PC_RESET;
    end else if (exec_fire && ex_pc_wr) begin
      pc_reg <= {ex_data[31:1], 1'b0};
    end else if (wr_acc && is_gpr && gpr_idx == MMX_IDX_PC) begin
      pc_reg <= pwdata;
    end
  end

  // Control word and special registers.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg    <= MMX_CTRL_RESET;
      psp_reg     <= 32'h0000_0000;
      primask_reg <= 1'b0;
      control_reg <= 2'h0;
    end else if (exec_fire && is_msr && cond_ok && ctrl_reg[MMX_CTRL_PRIV]) begin
      if (sel == MMX_SEL_PSP) psp_reg <= src_a;
      if (sel == MMX_SEL_PRIMASK) primask_reg <= src_a[0];
      if (sel == MMX_SEL_CONTROL) control_reg <= src_a[1:0];
    end else if (wr_acc) begin
      if (off == MMX_OFF_CTRL) ctrl_reg <= pwdata[2:0];
      if (off == MMX_OFF_PSP) psp_reg <= pwdata;
      if (off == MMX_OFF_PRIMASK) primask_reg <= pwdata[0];
      if (off == MMX_OFF_CONTROL) control_reg <= pwdata[1:0];
    end
  end

  // Read data is captured in the setup cycle and shown in the access cycle.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (is_gpr) prdata_reg <= (gpr_idx == MMX_IDX_PC) ? pc_reg : rf_c;
      else if (!hi_zero) prdata_reg <= 32'h0000_0000;
      else begin
        case (off)
          MMX_OFF_CTRL:    prdata_reg <= {29'h0000_0000, ctrl_reg};
          MMX_OFF_FLAGS:   prdata_reg <= {flags_reg, 28'h000_0000};
          MMX_OFF_STATUS:  prdata_reg <= {27'h000_0000, status_reg};
          MMX_OFF_PSP:     prdata_reg <= psp_reg;
          MMX_OFF_PRIMASK: prdata_reg <= {31'h0000_0000, primask_reg};
          MMX_OFF_CONTROL: prdata_reg <= {30'h0000_0000, control_reg};
          default:         prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ***************************************************************
  // Checks.
  // ***************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_fire_ok;
    exec_fire && cond_ok;
  endsequence

  property p_lsr_flags;
    s_fire_ok and (is_lsr && out_blk) |=> flags_reg[MMX_FLAG_N] == $past(lsr_res[31])
      && flags_reg[MMX_FLAG_Z] == ($past(lsr_res) == 32'h0) && flags_reg[MMX_FLAG_C] ==
      $past(lsr_c) && flags_reg[MMX_FLAG_V] == $past(flags_reg[MMX_FLAG_V]);
  endproperty
  a_lsr_flags: assert property (p_lsr_flags) else $error("shift flags wrong");

  property p_lsr_zero_fill;
    s_fire_ok and is_lsr && src_b[7:0] == 8'h04 |-> lsr_res[31:28] == 4'h0 && rf_we;
  endproperty
  a_lsr_zero_fill: assert property (p_lsr_zero_fill) else $error("shift fill wrong");

  property p_movi_write;
    s_fire_ok and is_movi |-> rf_we && rf_widx == {1'b0, hw2[10:8]}
      && rf_wdata == {24'h00_0000, hw2[7:0]};
  endproperty
  a_movi_write: assert property (p_movi_write) else $error("immediate move wrong");

  property p_block_keeps_flags;
    s_fire_ok and (is_movi || is_mul || is_lsr) && !out_blk |=> $stable(flags_reg);
  endproperty
  a_block_keeps_flags: assert property (p_block_keeps_flags) else $error("flags set");

  property p_movr_no_flags;
    s_fire_ok and is_movr |=> $stable(flags_reg);
  endproperty
  a_movr_no_flags: assert property (p_movr_no_flags) else $error("move set flags");

  property p_move_flag_setting_op_flags;
    s_fire_ok and is_move_flag_setting_op |=> flags_reg[MMX_FLAG_N] == $past(src_a[31])
      && flags_reg[1:0] == $past(flags_reg[1:0]);
  endproperty
  a_move_flag_setting_op_flags: assert property (p_move_flag_setting_op_flags) else $error("move flags wrong");

  property p_branch;
    s_fire_ok and is_movr && {hw2[7], hw2[2:0]} == MMX_IDX_PC |=>
      pc_reg == {$past(src_a[31:1]), 1'b0} && status_reg[MMX_ST_BRANCH] ##1 $stable(pc_reg);
  endproperty
  a_branch: assert property (p_branch) else $error("branch wrong");

  property p_mul_low;
    s_fire_ok and is_mul |-> rf_we && rf_widx == {1'b0, hw2[2:0]}
      && rf_wdata == 32'(src_a * src_b);
  endproperty
  a_mul_low: assert property (p_mul_low) else $error("product wrong");

  property p_cond_fail;
    exec_fire && !cond_ok |-> !rf_we ##1 $stable(flags_reg) && $stable(pc_reg);
  endproperty
  a_cond_fail: assert property (p_cond_fail) else $error("skipped word acted");

  property p_mrs_priv;
    s_fire_ok and is_mrs && !ctrl_reg[MMX_CTRL_PRIV] && sel == MMX_SEL_PSP |->
      !rf_we ##1 status_reg[MMX_ST_PRIV];
  endproperty
  a_mrs_priv: assert property (p_mrs_priv) else $error("privilege slip");

endmodule

/* File: testbench/mmx_exec_unit_test.sv */
`timescale 1ns/1ps
// ***************************************************************
// Bench for the move, multiply and shift unit over its APB port.
// ***************************************************************
module mmx_exec_unit_test;
  import mmx_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst     = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rdata;
  logic        rerr;
  int          n_fail   = 0;
  int          compares = 0;
  int          cycles   = 0;

  mmx_exec_unit mmx_exec_unit_i (
    .core_clk (core_clk),
    .nrst     (nrst),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr)
  );

  // Clock at 4 ns period, and a cycle ceiling that cuts a hang short.
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      close_out();
    end
  end

  // ***************************************************************
  // Bus tasks and comparison.
  // ***************************************************************
  // One APB transfer; request held until pready is seen high.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rdata   = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Read a register and compare the bits under the mask.
  task automatic rdm(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e & m, rdata & m);
  endtask

  task automatic ex(input logic [31:0] i);
    xfer(1'b1, {4'h0, MMX_OFF_INSTR}, i);
  endtask

  task automatic close_out();
    $display("Checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ***************************************************************
  // Main sequence.
  // ***************************************************************
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rdm(12'h000, 32'h5, 32'hFFFF_FFFF);
    rdm(12'h008, 32'h0, 32'hFFFF_FFFF);
    xfer(1'b1, 12'h008, 32'h1000_0000);
    xfer(1'b1, 12'h04C, 32'h8000_0018);
    xfer(1'b1, 12'h050, 32'h0000_0104);
    xfer(1'b1, 12'h058, 32'hFFFF_FFFF);
    xfer(1'b1, 12'h05C, 32'h3);
    ex(32'h40E3);
    rdm(12'h04C, 32'h0800_0001, 32'hFFFF_FFFF);
    rdm(12'h008, 32'h3000_0000, 32'hFFFF_FFFF);
    ex(32'h2000);
    rdm(12'h008, 32'h7000_0000, 32'hFFFF_FFFF);
    ex(32'h21FF);
    rdm(12'h044, 32'hFF, 32'hFFFF_FFFF);
    ex(32'h4699);
    rdm(12'h064, 32'h0800_0001, 32'hFFFF_FFFF);
    rdm(12'h008, 32'h3000_0000, 32'hFFFF_FFFF);
    ex(32'h4377);
    rdm(12'h05C, 32'hFFFF_FFFD, 32'hFFFF_FFFF);
    rdm(12'h008, 32'hB000_0000, 32'hFFFF_FFFF);
    ex(32'h0005);
    rdm(12'h008, 32'h7000_0000, 32'hFFFF_FFFF);
    ex(32'hF3EF_8200);
    rdm(12'h048, 32'h7000_0000, 32'hFFFF_FFFF);
    ex(32'hF383_8809);
    rdm(12'h014, 32'h0800_0001, 32'hFFFF_FFFF);
    ex(32'hF387_8814);
    rdm(12'h01C, 32'h1, 32'hFFFF_FFFF);
    ex(32'h468F);
    rdm(12'h07C, 32'hFE, 32'hFFFF_FFFF);
    rdm(12'h00C, 32'h2, 32'h2);
    ex(32'hF380_8800);
    rdm(12'h008, 32'h0, 32'hFFFF_FFFF);
    xfer(1'b1, 12'h000, 32'h3);
    xfer(1'b1, 12'h008, 32'hF000_0000);
    ex(32'h2200);
    rdm(12'h048, 32'h0, 32'hFFFF_FFFF);
    rdm(12'h008, 32'hF000_0000, 32'hFFFF_FFFF);
    ex(32'h4377);
    rdm(12'h05C, 32'h3, 32'hFFFF_FFFF);
    rdm(12'h008, 32'hF000_0000, 32'hFFFF_FFFF);
    xfer(1'b1, 12'h000, 32'h1);
    ex(32'hF381_8809);
    rdm(12'h014, 32'h0800_0001, 32'hFFFF_FFFF);
    rdm(12'h00C, 32'h4, 32'h4);
    ex(32'hF3EF_8209);
    rdm(12'h048, 32'h0, 32'hFFFF_FFFF);
    rdm(12'h00C, 32'h4, 32'h4);
    ex(32'hF3EF_8414);
    rdm(12'h050, 32'h1, 32'hFFFF_FFFF);
    xfer(1'b1, 12'h000, 32'h4);
    ex(32'h2105);
    rdm(12'h044, 32'hFF, 32'hFFFF_FFFF);
    rdm(12'h00C, 32'h10, 32'h10);
    rdm(12'h010, 32'h0, 32'hFFFF_FFFF);
    chk("pslverr", 32'h1, {31'h0, rerr});
    close_out();
  end
endmodule
